// File: rtl/terminal_bus_adapter_map.vh
// Constants for the terminal bus adapter: status layout and state codes
`ifndef TERMINAL_BUS_ADAPTER_MAP_VH
`define TERMINAL_BUS_ADAPTER_MAP_VH
`define STAT_BUS_BIT     0
`define STAT_TX_LSB      1
`define STAT_TX_MSB      4
`define STAT_RX_LSB      5
`define STAT_RX_MSB      7
`define RX_IDLE          3'h4
`define RX_PAR_A         3'h6
`define RX_PAR_B         3'h5
`define RX_FAULT_A       3'h2
`define RX_FAULT_B       3'h1
`define RX_FULL          3'h0
`define TX_TRIG          4'hF
`define TX_BUS_BUSY      4'hD
`define TX_ARB_FAULT     4'hB
`define TX_REPLY_FAULT   4'h9
`define TX_REC_BUSY      4'h7
`define TX_PAR_FAULT     4'h5
`define TX_TIME_FAULT    4'h3
`define TX_DONE          4'h1
`define TX_IDLE          4'h0
`define RAM_AW           8
`define RAM_DW           16
`endif

// File: rtl/adapter_word_ram.v
// Word RAM with registered read port for the adapter buffers
`default_nettype none
module adapter_word_ram (
    input  wire        core_clk,
    input  wire        wrEn,
    input  wire [7:0]  wrAddr,
    input  wire [15:0] wrData,
    input  wire [7:0]  rdAddr,
    output reg  [15:0] rdData_q
);
    reg [15:0] mem [0:255];
    always @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_q <= mem[rdAddr];
    end
endmodule // adapter_word_ram
`default_nettype wire

// File: rtl/terminal_bus_adapter.v
// Terminal bus adapter: byte port between a terminal and a dual word bus
// How it works
// [RL1] Byte-half flag high means next byte is the lower half.
// [RL2] Flag toggles when a buffer read or byte load strobe ends.
// [RL3] Either reset clears flag; terminal starts sequences with flag low.
// [RL4] Receive irq set on full block or fault, held until receiver reset.
// [RL5] Transmit irq set on done or fault, held until transmitter reset.
// [RL6] Buffer read drives RAM byte by flag; address advances after low half.
// [RL7] Terminal keeps buffer read low while receiver idle.
// [RL8] Status read drives bus bit, transmit state, receive state.
// [RL9] Bus-select falling edge latches data bit 0 as transmit bus.
// [RL10] Terminal keeps bus-select low while transmitter triggered.
// [RL11] Transmitter reset: idle, flag cleared, transmit irq cleared.
// [RL12] Receiver reset: idle, flag cleared, receive irq cleared.
// [RL13] Terminal never resets receiver while idle.
// [RL14] Address-load falling edge captures address; receiver uses it now.
// [RL15] Transmitter adopts address at start; header word untouched.
// [RL16] Start sends with latest address; resend allowed without reset.
// [RL17] Byte load fills half by flag; falling edge at high writes RAM.
// [RL18] Terminal loads bytes only while transmitter idle.
// [RL19] Upper-byte disable forces flag high, blocks upper byte, no toggle.
// [RL20] Receive-address load copies bus into receive RAM address counter.
// [RL21] Transmit inhibit stops acknowledges while still receiving.
// [RL22] Receiver idle, parity A, parity B, fault A codes as listed.
// [RL23] Incomplete block after error enters fault A or B with irq.
// [RL24] Error-free block enters full with irq; readable until reset.
// [RL25] Idle counts written words as length; start moves to triggered.
// [RL26] Triggered ends in one interrupting end state with its code.
// [RL27] Word bus side uses the existing transceiver protocol unchanged.
`default_nettype none
`include "terminal_bus_adapter_map.vh"
module terminal_bus_adapter (
    input  wire        core_clk,
    input  wire        rstn,
    input  wire [7:0]  termDataIn,
    output reg  [7:0]  termDataOut_q,
    output reg         termDataOe_q,
    input  wire        rx_buffer_read_strobe,
    input  wire        status_read_strobe,
    input  wire        tx_bus_select_strobe,
    input  wire        transmitter_reset_line,
    input  wire        receiver_reset_line,
    input  wire        own_address_load_strobe,
    input  wire        transmit_start_line,
    input  wire        tx_byte_load_strobe,
    input  wire        upper_byte_disable,
    input  wire        rx_address_load_strobe,
    input  wire        transmit_inhibit_line,
    output reg         byte_half_flag_q,
    output reg         receive_service_irq_q,
    output reg         transmit_service_irq_q,
    // Transceiver core side (protocol engine lives outside this block)
    input  wire        rxWordValid,
    input  wire [15:0] rxWord,
    input  wire        rxBlockDone,
    input  wire        rxParityErr,
    input  wire        rxIncomplete,
    input  wire        rxOnBusB,
    output reg  [7:0]  ownAddress_q,
    output reg         ackEnable_q,
    output reg         txRequest_q,
    output reg         txBusB_q,
    output reg  [7:0]  txAddress_q,
    output reg  [7:0]  txLength_q,
    output reg  [7:0]  txRdAddr_q,
    output wire [15:0] txRdData,
    input  wire        txWordTake,
    input  wire        txEndValid,
    input  wire [3:0]  txEndCode
);
    reg [2:0]  rxState_q;
    reg [3:0]  txState_q;
    reg [7:0]  rxRdAddr_q;
    reg [7:0]  rxWrAddr_q;
    reg [7:0]  txWrAddr_q;
    reg [7:0]  txUpper_q;
    reg [7:0]  txLower_q;
    reg        readPrev_q;
    reg        loadPrev_q;
    reg        selPrev_q;
    reg        adrPrev_q;
    wire [15:0] rxRdData;

    wire readEnd = readPrev_q & ~rx_buffer_read_strobe;
    wire loadEnd = loadPrev_q & ~tx_byte_load_strobe;
    wire selFall = selPrev_q & ~tx_bus_select_strobe;
    wire adrFall = adrPrev_q & ~own_address_load_strobe;
    wire txBusy  = (txState_q == `TX_TRIG);
    // Terminal strobes are slow, so the RAM's one-cycle read lag is hidden
    wire rxWrite = rxWordValid & (rxState_q == `RX_IDLE);

    adapter_word_ram rxRam (
        .core_clk (core_clk),
        .wrEn     (rxWrite),
        .wrAddr   (rxWrAddr_q),
        .wrData   (rxWord),
        .rdAddr   (rxRdAddr_q),
        .rdData_q (rxRdData)
    );

    adapter_word_ram txRam (
        .core_clk (core_clk),
        .wrEn     (loadEnd & byte_half_flag_q & (txState_q == `TX_IDLE)),
        .wrAddr   (txWrAddr_q),
        .wrData   ({txUpper_q, txLower_q}),
        .rdAddr   (txRdAddr_q),
        .rdData_q (txRdData)
    );

    // Edge history of the buffer read, byte load, bus-select and address-load strobes
    always @(posedge core_clk) begin
        if (!rstn) begin
            readPrev_q <= 1'b0;
            loadPrev_q <= 1'b0;
            selPrev_q  <= 1'b0;
            adrPrev_q  <= 1'b0;
        end else begin
            readPrev_q <= rx_buffer_read_strobe;
            loadPrev_q <= tx_byte_load_strobe;
            selPrev_q  <= tx_bus_select_strobe;
            adrPrev_q  <= own_address_load_strobe;
        end
    end

    // Byte-half flag
    always @(posedge core_clk) begin
        if (!rstn) begin
            byte_half_flag_q <= 1'b0;
        end else if (upper_byte_disable) begin
            byte_half_flag_q <= 1'b1; // RL19
        end else if (transmitter_reset_line || receiver_reset_line) begin
            byte_half_flag_q <= 1'b0; // RL3
        end else if (readEnd || loadEnd) begin
            byte_half_flag_q <= ~byte_half_flag_q; // RL2
        end
    end

    // Terminal data bus drive: status has priority over buffer read
    always @(posedge core_clk) begin
        if (!rstn) begin
            termDataOut_q <= 8'h00;
            termDataOe_q  <= 1'b0;
        end else if (status_read_strobe) begin
            termDataOut_q <= {rxState_q, txState_q, txBusB_q}; // RL8
            termDataOe_q  <= 1'b1;
        end else if (rx_buffer_read_strobe) begin
            termDataOut_q <= byte_half_flag_q ? rxRdData[7:0]
                                              : rxRdData[15:8]; // RL6 RL1
            termDataOe_q  <= 1'b1;
        end else begin
            termDataOut_q <= 8'h00;
            termDataOe_q  <= 1'b0;
        end
    end

    // Receiver: state, addresses and interrupt
    always @(posedge core_clk) begin
        if (!rstn) begin
            rxState_q             <= `RX_IDLE;
            rxRdAddr_q            <= 8'h00;
            rxWrAddr_q            <= 8'h00;
            receive_service_irq_q <= 1'b0;
        end else if (receiver_reset_line) begin
            rxState_q             <= `RX_IDLE; // RL12
            rxWrAddr_q            <= 8'h00;
            receive_service_irq_q <= 1'b0; // RL12
        end else begin
            if (rx_address_load_strobe) begin
                rxRdAddr_q <= termDataIn; // RL20
            end else if (readEnd && byte_half_flag_q) begin
                rxRdAddr_q <= rxRdAddr_q + 8'h01; // RL6
            end
            if (rxWrite) begin
                rxWrAddr_q <= rxWrAddr_q + 8'h01;
            end
            case (rxState_q)
                `RX_IDLE, `RX_PAR_A, `RX_PAR_B: begin
                    if (rxIncomplete) begin
                        rxState_q <= rxOnBusB ? `RX_FAULT_B
                                              : `RX_FAULT_A; // RL23 RL22
                        receive_service_irq_q <= 1'b1; // RL4
                    end else if (rxBlockDone && rxState_q == `RX_IDLE) begin
                        rxState_q             <= `RX_FULL; // RL24
                        receive_service_irq_q <= 1'b1; // RL4
                    end else if (rxParityErr) begin
                        rxState_q <= rxOnBusB ? `RX_PAR_B
                                              : `RX_PAR_A; // RL22
                    end
                end
                default: begin
                    rxState_q <= rxState_q;
                end
            endcase
        end
    end

    // Receiver matches against the live address; acks gated by inhibit
    always @(posedge core_clk) begin
        if (!rstn) begin
            ownAddress_q <= 8'h00;
            ackEnable_q  <= 1'b0;
        end else begin
            if (adrFall) begin
                ownAddress_q <= termDataIn; // RL14
            end
            ackEnable_q <= ~transmit_inhibit_line; // RL21 RL27
        end
    end

    // Transmit byte assembly
    always @(posedge core_clk) begin
        if (!rstn) begin
            txUpper_q <= 8'h00;
            txLower_q <= 8'h00;
        end else if (tx_byte_load_strobe) begin
            if (byte_half_flag_q) begin
                txLower_q <= termDataIn; // RL17
            end else if (!upper_byte_disable) begin
                txUpper_q <= termDataIn; // RL17 RL19
            end
        end
    end

    // Transmitter: state, length count, bus choice and interrupt
    always @(posedge core_clk) begin
        if (!rstn) begin
            txState_q              <= `TX_IDLE;
            txWrAddr_q             <= 8'h00;
            txLength_q             <= 8'h00;
            txRdAddr_q             <= 8'h00;
            txAddress_q            <= 8'h00;
            txBusB_q               <= 1'b0;
            txRequest_q            <= 1'b0;
            transmit_service_irq_q <= 1'b0;
        end else if (transmitter_reset_line) begin
            txState_q              <= `TX_IDLE; // RL11
            txWrAddr_q             <= 8'h00;
            txRequest_q            <= 1'b0;
            transmit_service_irq_q <= 1'b0; // RL11
        end else begin
            if (selFall && !txBusy) begin
                txBusB_q <= termDataIn[0]; // RL9
            end
            case (txState_q)
                `TX_IDLE: begin
                    if (loadEnd && byte_half_flag_q) begin
                        txWrAddr_q <= txWrAddr_q + 8'h01; // RL25
                    end
                    if (transmit_start_line) begin
                        txState_q   <= `TX_TRIG; // RL25
                        txLength_q  <= txWrAddr_q;
                        txAddress_q <= ownAddress_q; // RL15 RL16
                        txRdAddr_q  <= 8'h00;
                        txRequest_q <= 1'b1;
                    end
                end
                `TX_TRIG: begin
                    if (txWordTake) begin
                        txRdAddr_q <= txRdAddr_q + 8'h01;
                    end
                    if (txEndValid) begin
                        txState_q   <= txEndCode; // RL26
                        txRequest_q <= 1'b0;
                        transmit_service_irq_q <= 1'b1; // RL5
                    end
                end
                default: begin
                    // End states: a new start resends the held block
                    if (transmit_start_line) begin
                        txState_q   <= `TX_TRIG; // RL16
                        txAddress_q <= ownAddress_q; // RL15
                        txRdAddr_q  <= 8'h00;
                        txRequest_q <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule // terminal_bus_adapter
`default_nettype wire

// File: bench/tb_adapter_asserts.sv
// Port assertions and covers for the terminal bus adapter
`default_nettype none
module tb_adapter_asserts (
    input wire logic       core_clk, rstn, upper_byte_disable,
    input wire logic       transmitter_reset_line, receiver_reset_line,
    input wire logic       status_read_strobe, rx_buffer_read_strobe,
    input wire logic       tx_byte_load_strobe, transmit_start_line,
    input wire logic       transmit_inhibit_line, txEndValid,
    input wire logic       byte_half_flag_q, termDataOe_q, txBusB_q,
    input wire logic       transmit_service_irq_q, receive_service_irq_q,
    input wire logic       txRequest_q, ackEnable_q,
    input wire logic [7:0] termDataOut_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    flag_reset_a: assert property ((transmitter_reset_line ||
        receiver_reset_line) && !upper_byte_disable |=> !byte_half_flag_q)
        else $error("flag kept after a reset");
    flag_toggle_a: assert property ($fell(tx_byte_load_strobe) &&
        !upper_byte_disable |-> ##[1:2] $changed(byte_half_flag_q))
        else $error("flag did not toggle after a load");
    flag_forced_a: assert property (upper_byte_disable[*2]
        |-> byte_half_flag_q) else $error("flag not forced high");
    txirq_clear_a: assert property (transmitter_reset_line
        |=> !transmit_service_irq_q) else $error("tx irq kept");
    rxirq_clear_a: assert property (receiver_reset_line
        |=> !receive_service_irq_q) else $error("rx irq kept");
    stat_drive_a: assert property (status_read_strobe
        |=> termDataOe_q) else $error("status not driven");
    stat_bus_a: assert property (status_read_strobe[*3]
        |-> termDataOut_q[0] == txBusB_q) else $error("bus bit wrong");
    drive_drop_a: assert property ((!status_read_strobe &&
        !rx_buffer_read_strobe)[*2] |-> !termDataOe_q)
        else $error("bus driven without strobe");
    start_trig_a: assert property (transmit_start_line &&
        !transmitter_reset_line |=> txRequest_q) else $error("no start");
    end_irq_a: assert property (txRequest_q && txEndValid &&
        !transmitter_reset_line && !transmit_start_line
        |=> transmit_service_irq_q && !txRequest_q)
        else $error("end state without irq");
    ack_inhibit_a: assert property (transmit_inhibit_line
        |=> !ackEnable_q) else $error("ack while inhibited");
    cover property (status_read_strobe ##1 termDataOe_q);
    cover property (txEndValid ##1 transmit_service_irq_q);
    cover property ($rose(receive_service_irq_q));
endmodule // tb_adapter_asserts
bind terminal_bus_adapter tb_adapter_asserts u_tb_adapter_asserts (.*);
`default_nettype wire

// File: bench/transceiver_core_model.sv
// Behavioural word-bus transceiver engine that faces the adapter
`default_nettype none
module transceiver_core_model (
    input  wire logic        core_clk, txRequest_q, rxGo, rxBusB,
    input  wire logic [3:0]  endSel,
    input  wire logic [1:0]  rxKind,
    output logic             txEndValid, txWordTake, rxWordValid,
    output logic             rxBlockDone, rxParityErr, rxIncomplete,
    output logic             rxOnBusB,
    output logic [3:0]       txEndCode,
    output logic [15:0]      rxWord
);
    logic [2:0] txCnt = 3'h0;
    logic [2:0] rxCnt = 3'h0;
    initial rxWord = 16'h0000;
    assign rxOnBusB = rxBusB;
    // Arbitration and parity are abstracted to a fixed latency
    always @(posedge core_clk) begin
        txCnt <= (txRequest_q && txCnt < 3'h6) ? txCnt + 3'h1 : 3'h0;
        txWordTake <= txRequest_q && (txCnt == 3'h1 || txCnt == 3'h2);
        txEndValid <= txRequest_q && txCnt == 3'h5;
        // Code lines carry junk outside the end pulse
        txEndCode <= (txRequest_q && txCnt == 3'h5) ? endSel : ~endSel;
        rxCnt <= rxGo ? 3'h1 : (rxCnt != 3'h0 ? rxCnt + 3'h1 : 3'h0);
        rxWordValid <= rxKind == 2'h1 && (rxCnt == 3'h1 || rxCnt == 3'h2);
        rxWord <= rxCnt == 3'h1 ? 16'hA5C3 :
                  rxCnt == 3'h2 ? 16'h3C5A : ~rxWord;
        rxBlockDone <= rxCnt == 3'h3 && rxKind == 2'h1;
        rxParityErr <= rxCnt == 3'h3 && rxKind == 2'h2;
        rxIncomplete <= rxCnt == 3'h3 && rxKind == 2'h3;
    end
endmodule // transceiver_core_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the terminal bus adapter
`default_nettype none
`include "terminal_bus_adapter_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0, rstn = 1'h0, rxGo = 1'h0, rxBusB = 1'h0;
    logic [7:0] termDataIn = 8'h00, rd, termDataOut_q, ownAddress_q;
    logic [7:0] txAddress_q, txLength_q, txRdAddr_q;
    logic [15:0] txRdData, rxWord;
    logic [3:0] endSel = 4'h0, txEndCode;
    logic [1:0] rxKind = 2'h0;
    logic rx_buffer_read_strobe = 1'h0, status_read_strobe = 1'h0;
    logic tx_bus_select_strobe = 1'h0, transmitter_reset_line = 1'h0;
    logic receiver_reset_line = 1'h0, own_address_load_strobe = 1'h0;
    logic transmit_start_line = 1'h0, tx_byte_load_strobe = 1'h0;
    logic upper_byte_disable = 1'h0, rx_address_load_strobe = 1'h0;
    logic transmit_inhibit_line = 1'h0;
    logic termDataOe_q, byte_half_flag_q, receive_service_irq_q;
    logic transmit_service_irq_q, ackEnable_q, txRequest_q, txBusB_q;
    logic rxWordValid, rxBlockDone, rxParityErr, rxIncomplete, rxOnBusB;
    logic txWordTake, txEndValid;
    logic [3:0] codes [7] = '{`TX_BUS_BUSY, `TX_ARB_FAULT,
        `TX_REPLY_FAULT, `TX_REC_BUSY, `TX_PAR_FAULT, `TX_TIME_FAULT,
        `TX_DONE};
    logic [7:0] rxBytes [4] = '{8'hA5, 8'hC3, 8'h3C, 8'h5A};
    logic [2:0] faults [2] = '{`RX_FAULT_A, `RX_FAULT_B};
    logic [2:0] parities [2] = '{`RX_PAR_A, `RX_PAR_B};
    int fail_count = 0, cmp_count = 0, k;
    terminal_bus_adapter u_terminal_bus_adapter (.*);
    transceiver_core_model u_transceiver_core_model (.*);
    initial forever #4 core_clk = ~core_clk;
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Strobe held three cycles so the registered RAM read settles
    task automatic pulse(ref logic s, input logic [7:0] d);
        @(posedge core_clk) #1 s = 1'h1;
        termDataIn = d;
        repeat (3) @(posedge core_clk);
        #1 rd = termDataOut_q;
        s = 1'h0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic level(ref logic s);
        @(posedge core_clk) #1 s = 1'h1;
        @(posedge core_clk) #1 s = 1'h0;
    endtask
    task rxsend(input logic [1:0] kind);
        @(posedge core_clk) #1 rxKind = kind;
        rxGo = 1'h1;
        @(posedge core_clk) #1 rxGo = 1'h0;
        repeat (8) @(posedge core_clk);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rstn = 1'h1;
        pulse(status_read_strobe, 8'h00);
        chk("status", rd, {`RX_IDLE, `TX_IDLE, 1'h0});
        level(transmitter_reset_line);
        chk("flag", byte_half_flag_q, 1'h0);
        pulse(tx_byte_load_strobe, 8'h12);
        chk("flag", byte_half_flag_q, 1'h1);
        pulse(tx_byte_load_strobe, 8'h34);
        chk("flag", byte_half_flag_q, 1'h0);
        chk("txword", txRdData, 16'h1234);
        pulse(tx_byte_load_strobe, 8'h56);
        pulse(tx_byte_load_strobe, 8'h78);
        pulse(tx_bus_select_strobe, 8'h01);
        pulse(own_address_load_strobe, 8'h5A);
        chk("ownaddr", ownAddress_q, 16'h005A);
        pulse(status_read_strobe, 8'h00);
        chk("busbit", rd[0], 1'h1);
        $display("test load done");
        foreach (codes[i]) begin
            endSel = codes[i];
            level(transmit_start_line);
            chk("request", txRequest_q, 1'h1);
            for (k = 0; k < 40 && txRequest_q; k++) @(posedge core_clk);
            if (txRequest_q) begin
                fail_count++;
                stop_test;
            end
            pulse(status_read_strobe, 8'h00);
            chk("txstate", rd[4:1], codes[i]);
            chk("txirq", transmit_service_irq_q, 1'h1);
        end
        chk("txaddr", txAddress_q, 16'h005A);
        // Length is latched at the first start; resends keep it
        chk("length", txLength_q, 16'h0002);
        level(transmitter_reset_line);
        chk("txirq", transmit_service_irq_q, 1'h0);
        $display("test transmit done");
        rxsend(2'h1);
        chk("rxirq", receive_service_irq_q, 1'h1);
        pulse(status_read_strobe, 8'h00);
        chk("rxstate", rd[7:5], `RX_FULL);
        pulse(rx_address_load_strobe, 8'h00);
        level(transmitter_reset_line);
        foreach (rxBytes[i]) begin
            pulse(rx_buffer_read_strobe, 8'h00);
            chk("rxbyte", rd, rxBytes[i]);
        end
        level(receiver_reset_line);
        chk("rxirq", receive_service_irq_q, 1'h0);
        for (int b = 0; b < 2; b++) begin
            rxBusB = b[0];
            rxsend(2'h2);
            pulse(status_read_strobe, 8'h00);
            chk("parity", rd[7:5], parities[b]);
            rxsend(2'h3);
            pulse(status_read_strobe, 8'h00);
            chk("fault", rd[7:5], faults[b]);
            chk("rxirq", receive_service_irq_q, 1'h1);
            level(receiver_reset_line);
        end
        $display("test receive done");
        upper_byte_disable = 1'h1;
        pulse(tx_byte_load_strobe, 8'h9A);
        chk("flag", byte_half_flag_q, 1'h1);
        #1 upper_byte_disable = 1'h0;
        transmit_inhibit_line = 1'h1;
        repeat (2) @(posedge core_clk);
        chk("ack", ackEnable_q, 1'h0);
        #1 transmit_inhibit_line = 1'h0;
        repeat (2) @(posedge core_clk);
        chk("ack", ackEnable_q, 1'h1);
        $display("test misc done");
        stop_test;
    end
endmodule // tb_top
`default_nettype wire
